// [include/amda_pkg.sv]
// ----------------------------------------------------------------
// alternate master default memory acknowledge constants
// ----------------------------------------------------------------
package amda_pkg;
    localparam int ADDR_W = 28;
    localparam int WS_W = 4;
    localparam logic [WS_W-1:0] WS_ZERO = 4'h0;
    localparam logic [WS_W-1:0] WS_ONE = 4'h1;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LINE = 2'h3;
    localparam logic ACK_ON = 1'b0;
    localparam logic ACK_OFF = 1'b1;
    localparam logic OE_DRIVE = 1'b0;
    localparam logic OE_FLOAT = 1'b1;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_DECODE = 5'h02,
        ST_WAIT = 5'h04,
        ST_ACK = 5'h08,
        ST_NEGATE = 5'h10
    } amda_state_t;
endpackage

// [logic/amda_ws_counter.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// wait-state down counter
// ----------------------------------------------------------------
module amda_ws_counter
    import amda_pkg::*;
(
    input wire logic mclk, // bus clock
    input wire logic rst, // sync reset, active high
    input wire logic load, // load start value
    input wire logic [WS_W-1:0] load_val, // programmed wait states
    output logic [WS_W-1:0] count // remaining wait states
);
    logic [WS_W-1:0] count_q;

    // saturates at zero so a stray tick never wraps
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_q <= WS_ZERO;
        end else if (load) begin
            count_q <= load_val;
        end else if (count_q != WS_ZERO) begin
            count_q <= count_q - WS_ONE;
        end
    end

    assign count = count_q;
endmodule // amda_ws_counter

// [logic/amda_ack_ctrl.sv]
`timescale 1ns/1ps
// Function
// RULE1 - one extra decode clock before counting
// RULE2 - decode registered address during extra clock
// RULE3 - master drives address, controls, read high
// RULE4 - master drives size code and start
// RULE5 - capture address, direction, size at C2
// RULE6 - auto ack enabled: load programmed wait count
// RULE7 - master negates start, samples acknowledge
// RULE8 - zero waits: acknowledge asserted at C3
// RULE9 - nonzero waits: drive negated, then assert
// RULE10 - master latches read data on acknowledge
// RULE11 - master waits while acknowledge negated
// RULE12 - negate acknowledge, then release next clock
// RULE13 - memory releases data after acknowledge
// RULE14 - write: master holds direction low
// RULE15 - write: master drives data in C2
// RULE16 - write: master holds data during waits
// RULE17 - write: memory latches data when ready
// RULE18 - write: master floats data after acknowledge
// RULE19 - support 8, 16, 32 bit ports
// RULE20 - only when no chip select, DRAM hit
// RULE21 - delay equals programmed wait-state count
// RULE22 - master starts aligned transfers only; the bench master also starts misaligned ones, which get no acknowledge
// RULE23 - auto ack disabled: leave acknowledge undriven
module amda_ack_ctrl
    import amda_pkg::*;
(
    input wire logic mclk, // bus clock
    input wire logic rst, // sync reset, active high
    input wire logic alt_master_owns, // bus granted to the other master
    input wire logic transfer_start_n, // bus cycle start, low active
    input wire logic [ADDR_W-1:0] addr, // alternate master address
    input wire logic read_not_write, // high for read
    input wire logic [1:0] xfer_width_code, // transfer size
    input wire logic ext_master_auto_ack_en, // default memory auto ack
    input wire logic [WS_W-1:0] dm_wait_states, // default memory wait states
    input wire logic cs_region_hit, // chip select decode of cap_addr
    input wire logic dram_bank_hit, // dram decode of cap_addr
    output logic [ADDR_W-1:0] cap_addr, // registered address
    output logic cap_read, // registered direction
    output logic [1:0] cap_size, // registered size
    output logic dm_active, // default memory ack sequence running
    output logic xfer_ack_n, // acknowledge level, low active
    output logic xfer_ack_oe_n // acknowledge drive enable, low drives
);
    amda_state_t state_q, state_d;
    logic [ADDR_W-1:0] cap_addr_q;
    logic cap_read_q;
    logic [1:0] cap_size_q;
    logic ack_n_q, ack_n_d;
    logic ack_oe_n_q, ack_oe_n_d;
    logic dm_active_q;
    logic start;
    logic aligned;
    logic take;
    logic ws_load;
    logic [WS_W-1:0] ws_count;
    logic [WS_W-1:0] ws_lat_q;
    logic [WS_W-1:0] elapsed_q;

    // ----------------------------------------------------------------
    // capture
    // ----------------------------------------------------------------
    // starts while a sequence runs are ignored; the master cannot start
    // a new cycle before it has seen the acknowledge anyway
    assign start = alt_master_owns && !transfer_start_n && (state_q == ST_IDLE);

    always_ff @(posedge mclk) begin
        if (rst) begin
            cap_addr_q <= '0;
            cap_read_q <= 1'b0;
            cap_size_q <= SIZE_LONG;
        end else if (start) begin // RULE5
            cap_addr_q <= addr;
            cap_read_q <= read_not_write;
            cap_size_q <= xfer_width_code;
        end
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // misaligned or line-size cycles get no acknowledge from here
    always_comb begin
        case (cap_size_q) // RULE19
            SIZE_BYTE: aligned = 1'b1;
            SIZE_WORD: aligned = (cap_addr_q[0] == 1'b0);
            SIZE_LONG: aligned = (cap_addr_q[1:0] == 2'h0);
            default: aligned = 1'b0;
        endcase
    end

    // RULE2 RULE20 RULE23
    assign take = ext_master_auto_ack_en && !cs_region_hit && !dram_bank_hit && aligned;
    assign ws_load = (state_q == ST_DECODE) && take; // RULE6

    amda_ws_counter u_ws (
        .mclk(mclk),
        .rst(rst),
        .load(ws_load),
        .load_val(dm_wait_states),
        .count(ws_count)
    );

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        ack_n_d = ACK_OFF;
        ack_oe_n_d = OE_FLOAT;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_DECODE; // RULE1
                end
            end
            ST_DECODE: begin
                if (!take) begin
                    state_d = ST_IDLE; // RULE23
                end else if (dm_wait_states == WS_ZERO) begin
                    state_d = ST_ACK; // RULE8
                    ack_n_d = ACK_ON;
                    ack_oe_n_d = OE_DRIVE;
                end else begin
                    state_d = ST_WAIT; // RULE9
                    ack_oe_n_d = OE_DRIVE;
                end
            end
            ST_WAIT: begin
                ack_oe_n_d = OE_DRIVE;
                if (ws_count == WS_ONE) begin
                    state_d = ST_ACK; // RULE21
                    ack_n_d = ACK_ON;
                end
            end
            ST_ACK: begin
                state_d = ST_NEGATE; // RULE12
                ack_oe_n_d = OE_DRIVE;
            end
            ST_NEGATE: begin
                state_d = ST_IDLE; // RULE12
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_n_q <= ACK_OFF;
            ack_oe_n_q <= OE_FLOAT;
        end else begin
            ack_n_q <= ack_n_d;
            ack_oe_n_q <= ack_oe_n_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            dm_active_q <= 1'b0;
        end else begin
            dm_active_q <= (state_d == ST_WAIT) || (state_d == ST_ACK) || (state_d == ST_NEGATE);
        end
    end

    assign cap_addr = cap_addr_q;
    assign cap_read = cap_read_q;
    assign cap_size = cap_size_q;
    assign dm_active = dm_active_q;
    assign xfer_ack_n = ack_n_q;
    assign xfer_ack_oe_n = ack_oe_n_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // helper: wait states seen before the acknowledge
    always_ff @(posedge mclk) begin
        if (rst) begin
            ws_lat_q <= WS_ZERO;
            elapsed_q <= WS_ZERO;
        end else if (ws_load) begin
            ws_lat_q <= dm_wait_states;
            elapsed_q <= WS_ZERO;
        end else if (state_q == ST_WAIT) begin
            elapsed_q <= elapsed_q + WS_ONE;
        end
    end

    capture_regs_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
        start |=> (cap_addr_q == $past(addr)) && (cap_read_q == $past(read_not_write))
            && (cap_size_q == $past(xfer_width_code)))
        else $error("transfer fields not captured");

    decode_gap_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
        start |=> (state_q == ST_DECODE) && (ack_oe_n_q == OE_FLOAT))
        else $error("acknowledge driven during decode clock");

    zero_wait_a: assert property (@(posedge mclk) disable iff (rst) // RULE8
        (state_q == ST_DECODE && take && dm_wait_states == WS_ZERO)
            |=> (ack_n_q == ACK_ON) && (ack_oe_n_q == OE_DRIVE))
        else $error("zero wait acknowledge not at third clock");

    wait_negated_a: assert property (@(posedge mclk) disable iff (rst) // RULE9
        (state_q == ST_DECODE && take && dm_wait_states != WS_ZERO)
            |=> (ack_n_q == ACK_OFF) && (ack_oe_n_q == OE_DRIVE))
        else $error("acknowledge not driven negated during waits");

    wait_count_a: assert property (@(posedge mclk) disable iff (rst) // RULE21
        $fell(ack_n_q) |-> (elapsed_q == ws_lat_q))
        else $error("acknowledge delay differs from wait count");

    negate_release_a: assert property (@(posedge mclk) disable iff (rst) // RULE12
        (ack_n_q == ACK_ON) |=> (ack_n_q == ACK_OFF) && (ack_oe_n_q == OE_DRIVE)
            ##1 (ack_oe_n_q == OE_FLOAT))
        else $error("acknowledge not negated then released");

    no_auto_a: assert property (@(posedge mclk) disable iff (rst) // RULE23
        (state_q == ST_DECODE && !ext_master_auto_ack_en) |=> (ack_oe_n_q == OE_FLOAT)[*2])
        else $error("acknowledge driven with auto ack off");

    region_hit_a: assert property (@(posedge mclk) disable iff (rst) // RULE20
        (state_q == ST_DECODE && (cs_region_hit || dram_bank_hit))
            |=> (state_q == ST_IDLE) && (ack_oe_n_q == OE_FLOAT))
        else $error("default acknowledge on other region");

    size_align_a: assert property (@(posedge mclk) disable iff (rst) // RULE19
        (state_q == ST_DECODE && ext_master_auto_ack_en && !cs_region_hit && !dram_bank_hit
            && cap_size_q == SIZE_WORD && !cap_addr_q[0]) |=> (ack_oe_n_q == OE_DRIVE))
        else $error("aligned word transfer not acknowledged");
endmodule // amda_ack_ctrl

// [verification/amda_alt_master.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// alternate bus master model
// ----------------------------------------------------------------
module amda_alt_master
    import amda_pkg::*;
(
    input wire logic mclk, // bus clock
    input wire logic go, // request one transfer
    input wire logic [ADDR_W-1:0] go_addr, // address to present
    input wire logic go_rnw, // direction to present
    input wire logic [1:0] go_size, // size to present
    input wire logic ack_n, // device acknowledge level
    input wire logic ack_oe_n, // device acknowledge enable
    output logic transfer_start_n, // cycle start
    output logic [ADDR_W-1:0] addr, // address bus
    output logic read_not_write, // direction
    output logic [1:0] xfer_width_code, // size
    output logic busy, // transfer running
    output logic [7:0] acks, // edges with pin asserted
    output logic [7:0] waits, // negated edges before acknowledge
    output logic [7:0] drv, // edges with pin driven
    output logic [31:0] rd_word // word latched on a read
);
    logic pin;
    logic [31:0] data_bus; // data lines as the model sees them
    logic [31:0] mem_word; // word held by the addressed memory
    // pulled up while floating, so a released pin reads negated
    assign pin = (ack_oe_n === OE_DRIVE) ? ack_n : 1'b1;
    initial begin
        transfer_start_n = 1'b1;
        busy = 1'b0;
        mem_word = 32'h0;
        data_bus = 'z;
    end
    always begin
        @(negedge mclk);
        if (go === 1'b1 && !busy) begin
            busy = 1'b1;
            acks = 8'h00;
            waits = 8'h00;
            drv = 8'h00;
            addr = go_addr;
            read_not_write = go_rnw;
            xfer_width_code = go_size;
            transfer_start_n = 1'b0;
            @(negedge mclk);
            transfer_start_n = 1'b1;
            if (go_rnw) data_bus = mem_word; // memory drives read data
            else data_bus = {4'h0, go_addr};
            // watches past the end so a late or doubled pulse shows
            // long enough for the largest wait count plus negate and release
            for (int i = 0; i < 20; i++) begin
                @(posedge mclk);
                #1;
                if (acks != 8'h00) data_bus = 'z;
                if (pin === 1'b0 && acks == 8'h00) begin
                    if (go_rnw) rd_word = data_bus;
                    else mem_word = data_bus;
                end
                if (pin === 1'b0) acks++;
                else if (acks == 8'h00) waits++;
                if (ack_oe_n === OE_DRIVE) drv++;
            end
            addr = ~go_addr;
            read_not_write = ~go_rnw;
            busy = 1'b0;
        end
    end
endmodule // amda_alt_master

// [verification/amda_ack_ctrl_test.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module amda_ack_ctrl_test
    import amda_pkg::*;
;
    logic mclk = 1'b0, rst = 1'b1, go = 1'b0, go_rnw = 1'b0, owns = 1'b0, en = 1'b0;
    logic cs_hit = 1'b0, dr_hit = 1'b0, ts_n, rnw, cap_read, dm_active, ack_n, ack_oe_n, busy;
    logic [ADDR_W-1:0] go_addr = '0, addr, cap_addr;
    logic [1:0] go_size = 2'h0, size, cap_size;
    logic [WS_W-1:0] ws = 4'h0;
    logic [7:0] acks, waits, drv;
    logic [31:0] last_wr = 32'h0, rd_word;
    int n_fail = 0, total_checks = 0, cycles = 0, act = 0;
    always #20 mclk = ~mclk;
    amda_ack_ctrl uut (.mclk(mclk), .rst(rst), .alt_master_owns(owns),
        .transfer_start_n(ts_n), .addr(addr), .read_not_write(rnw), .xfer_width_code(size),
        .ext_master_auto_ack_en(en), .dm_wait_states(ws), .cs_region_hit(cs_hit),
        .dram_bank_hit(dr_hit), .cap_addr(cap_addr), .cap_read(cap_read), .cap_size(cap_size),
        .dm_active(dm_active), .xfer_ack_n(ack_n), .xfer_ack_oe_n(ack_oe_n));
    amda_alt_master master (.mclk(mclk), .go(go), .go_addr(go_addr), .go_rnw(go_rnw),
        .go_size(go_size), .ack_n(ack_n), .ack_oe_n(ack_oe_n), .transfer_start_n(ts_n),
        .addr(addr), .read_not_write(rnw), .xfer_width_code(size), .busy(busy), .acks(acks),
        .waits(waits), .drv(drv), .rd_word(rd_word));
    // dm_active counted at falling edges, where it has settled
    always @(negedge mclk) begin
        if (dm_active === 1'b1) act++;
    end
    task summarize();
        if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            summarize();
        end
    end
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (exp !== got) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask
    // env is {owns, chip select hit, dram hit}
    task run(input logic [ADDR_W-1:0] a, input logic r, input logic [1:0] s, input logic e,
        input logic [WS_W-1:0] w, input logic [2:0] env, input logic ok);
        @(negedge mclk);
        act = 0;
        {go_addr, go_rnw, go_size, en, ws} <= {a, r, s, e, w};
        {owns, cs_hit, dr_hit} <= env;
        go <= 1'b1;
        @(negedge mclk);
        go <= 1'b0;
        @(negedge mclk);
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge mclk);
        chk("acks", {31'h0, ok}, {24'h0, acks});
        chk("waits", ok ? {28'h0, w} : 32'h14, {24'h0, waits});
        chk("drive", ok ? {28'h0, w} + 32'h2 : 32'h0, {24'h0, drv});
        chk("active", ok ? {28'h0, w} + 32'h2 : 32'h0, act);
        if (env[2]) chk("captured", {1'b0, a, r, s}, {1'b0, cap_addr, cap_read, cap_size});
        if (ok && r) chk("read data", last_wr, rd_word);
        if (ok && !r) last_wr = {4'h0, a};
    endtask
    task t_read_nowait();
        run(28'h0000100, 1'b1, SIZE_LONG, 1'b1, WS_ZERO, 3'h4, 1'b1);
    endtask
    task t_write_waits();
        run(28'h0abc002, 1'b0, SIZE_WORD, 1'b1, 4'h3, 3'h4, 1'b1);
        run(28'h0fffffc, 1'b0, SIZE_LONG, 1'b1, 4'hf, 3'h4, 1'b1);
    endtask
    task t_sizes();
        logic [1:0] s [3];
        s = '{SIZE_BYTE, SIZE_WORD, SIZE_LONG};
        for (int i = 0; i < 3; i++) run(28'h0000204, i[0], s[i], 1'b1, WS_ONE, 3'h4, 1'b1);
    endtask
    task t_disabled();
        run(28'h0000300, 1'b1, SIZE_LONG, 1'b0, WS_ZERO, 3'h4, 1'b0);
    endtask
    task t_regions();
        run(28'h0000400, 1'b1, SIZE_LONG, 1'b1, WS_ZERO, 3'h6, 1'b0);
        run(28'h0000404, 1'b0, SIZE_LONG, 1'b1, WS_ZERO, 3'h5, 1'b0);
        run(28'h0000408, 1'b1, SIZE_LONG, 1'b1, WS_ZERO, 3'h0, 1'b0);
    endtask
    task t_misaligned();
        run(28'h0000501, 1'b1, SIZE_WORD, 1'b1, WS_ZERO, 3'h4, 1'b0);
        run(28'h0000502, 1'b0, SIZE_LONG, 1'b1, WS_ZERO, 3'h4, 1'b0);
        run(28'h0000500, 1'b1, SIZE_LINE, 1'b1, WS_ZERO, 3'h4, 1'b0);
    endtask
    initial begin
        repeat (8) @(negedge mclk);
        rst <= 1'b0;
        t_read_nowait();
        t_write_waits();
        t_sizes();
        t_disabled();
        t_regions();
        t_misaligned();
        summarize();
    end
endmodule // amda_ack_ctrl_test
